// ---- rtl/ncb_map.vh ----
`ifndef NCB_MAP_VH
`define NCB_MAP_VH
// ************************************************************
// cycle type status codes, active-low lines (s2 s1 s0)
// ************************************************************
`define NCB_CYC_READ 3'h5
`define NCB_CYC_WRITE 3'h6
`define NCB_CYC_PASSIVE 3'h7
`define NCB_CYC_FETCH 3'h4
// ************************************************************
// queue tracking status codes
// ************************************************************
`define NCB_Q_NOP 2'h0
`define NCB_Q_FIRST 2'h1
`define NCB_Q_EMPTY 2'h2
`define NCB_Q_NEXT 2'h3
// ************************************************************
// upper status levels on own cycles (s3 s4 s5 s6)
// ************************************************************
`define NCB_US3 1'b1
`define NCB_US4 1'b1
`define NCB_US5 1'b0
`define NCB_US6 1'b1
// ************************************************************
// escape opcode pattern and timing
// ************************************************************
`define NCB_ESC_MASK 8'hf8
`define NCB_ESC_CODE 8'hd8
`define NCB_GNT_DELAY 2'h2
`define NCB_REL_DELAY 2'h1
`define NCB_BCD_DIGITS 18
`define NCB_INT_WIDTH 64
`endif

// ---- rtl/ncb_sync.v ----
// two flip-flop synchroniser, first stage read only by second
module ncb_sync #(
    parameter WIDTH = 1
) (
    input wire clk_sys,
    input wire resetn,
    input wire [WIDTH-1:0] din,
    input wire [WIDTH-1:0] init,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage;
    // ************************************************************
    // synchronise
    // ************************************************************
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            stage <= init;
            dout <= init;
        end
        else
        begin
            stage <= din;
            dout <= stage;
        end
    end
endmodule

// ---- rtl/ncb_port.v ----
// Functional notes
// RL1: works only as coprocessor beside a maximum-mode host, never alone.
// RL2: follows host cycle status and queue status to decode instruction stream.
// RL3: once started, an operation runs on independently of the host.
// RL4: busy stays high while executing; host wait samples it.
// RL5: error or exception raises the interrupt request output.
// RL6: primary handshake line obtains the local bus for operand transfers.
// RL7: relay secondary master when not owner; hand bus directly when owner.
// RL8: host-side master first come first served; secondary master outranks device.
// RL9: translating controller uses secondary line only while device owns bus.
// RL10: controller withholds grant until third processor drops system hold.
// RL11: fixed priority third processor, then device, then host.
// RL12: own cycles multiplex address with data and address with upper status.
// RL13: own cycles drive status three, four, six high and five low.
// RL14: passive watching uses status six low to spot host cycles.
// RL15: status seven equals high byte enable on own cycles.
// RL16: packed decimal operands up to 18 digits handled exactly.
// RL17: integer operands up to 64 bits wide.
// RL18: exchange is request, grant, release pulses, active low, one clock each.
// RL19: at least one idle clock between exchanges.
// RL20: relay request one clock later, grant two, release one.
// RL21: release one clock after last own cycle, or on secondary release.
// RL22: handshakes synchronous to one clock, inactive high after reset.
`include "ncb_map.vh"
module ncb_port #(
    parameter BCD_DIGITS = `NCB_BCD_DIGITS, // RL16
    parameter INT_WIDTH = `NCB_INT_WIDTH // RL17
) (
    input wire clk_sys,
    input wire resetn,
    input wire [2:0] cycle_type_status,
    input wire [1:0] queue_tracking_status,
    input wire upper_status_six,
    input wire [7:0] bus_data_in,
    input wire primary_bus_handshake_in,
    output wire primary_bus_handshake_out,
    output wire primary_bus_handshake_oe,
    input wire secondary_bus_handshake_in,
    output wire secondary_bus_handshake_out,
    output wire secondary_bus_handshake_oe,
    input wire xfer_req,
    input wire xfer_last,
    output reg xfer_go,
    output reg bus_owned,
    input wire exec_done,
    input wire exec_error,
    output reg esc_seen,
    output reg busy,
    output reg int_req,
    output reg [3:0] upper_status_drive,
    input wire high_byte_enable,
    output reg upper_status_seven
);
    // state codes
    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT_GNT = 3'h1;
    localparam ST_OWN = 3'h2;
    localparam ST_LEND = 3'h3;
    localparam ST_REL = 3'h4;
    localparam ST_RELAY = 3'h5;
    localparam ST_DEAD = 3'h6;

    wire [2:0] cyc_s;
    wire [1:0] qs_s;
    wire s6_s;
    wire [7:0] dat_s;
    wire p_in_s;
    wire s_in_s;
    reg [2:0] state;
    reg [2:0] next_state;
    reg p_low;
    reg s_low;
    reg next_p_low;
    reg next_s_low;
    reg [1:0] gnt_cnt;
    reg host_cycle;
    reg req_pend;
    reg p_d1;
    reg p_d2;
    reg s_d1;
    reg s_d2;
    wire p_seen;
    wire s_seen;

    // ************************************************************
    // synchronise pins
    // ************************************************************
    ncb_sync #(.WIDTH(16)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din({cycle_type_status, queue_tracking_status, upper_status_six, bus_data_in,
            primary_bus_handshake_in, secondary_bus_handshake_in}),
        .init({`NCB_CYC_PASSIVE, `NCB_Q_NOP, 1'b1, 8'h00, 1'b1, 1'b1}),
        .dout({cyc_s, qs_s, s6_s, dat_s, p_in_s, s_in_s})
    ); // RL22

    // open-drain style handshakes: drive only while pulsing low
    assign primary_bus_handshake_out = 1'b0;
    assign primary_bus_handshake_oe = p_low; // RL18 RL22
    assign secondary_bus_handshake_out = 1'b0;
    assign secondary_bus_handshake_oe = s_low; // RL18 RL22

    // own pulses come back through the synchroniser two clocks later
    assign p_seen = !p_in_s && !p_d2; // RL22
    assign s_seen = !s_in_s && !s_d2; // RL22

    // escape decode: byte opcode match
    function is_esc;
        input [7:0] op;
        begin
            is_esc = (op & `NCB_ESC_MASK) == `NCB_ESC_CODE;
        end
    endfunction

    // ************************************************************
    // instruction tracking and execution status
    // ************************************************************
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            host_cycle <= 1'b0;
            esc_seen <= 1'b0;
            busy <= 1'b0;
            int_req <= 1'b0;
        end
        else
        begin
            // host is the only master driving status six low
            host_cycle <= (cyc_s != `NCB_CYC_PASSIVE) ? !s6_s : host_cycle; // RL14
            esc_seen <= (qs_s == `NCB_Q_FIRST) && is_esc(dat_s) && host_cycle; // RL1 RL2
            if (esc_seen)
                busy <= 1'b1; // RL4
            else if (exec_done && !int_req)
                busy <= 1'b0; // RL3
            // exception keeps busy until cleared by a new escape
            if (exec_error)
                int_req <= 1'b1; // RL5
            else if (esc_seen)
                int_req <= 1'b0;
        end
    end

    // ************************************************************
    // upper status on own cycles
    // ************************************************************
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            upper_status_drive <= 4'hf;
            upper_status_seven <= 1'b1;
        end
        else
        begin
            upper_status_drive <= {`NCB_US6, `NCB_US5, `NCB_US4, `NCB_US3}; // RL12 RL13
            upper_status_seven <= high_byte_enable; // RL15
        end
    end

    // ************************************************************
    // request/grant handshake state machine
    // ************************************************************
    always @*
    begin
        next_state = state;
        next_p_low = 1'b0;
        next_s_low = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (s_seen)
                begin
                    next_p_low = 1'b1; // RL7 RL20
                    next_state = ST_RELAY;
                end
                else if (xfer_req || req_pend)
                begin
                    next_p_low = 1'b1; // RL6
                    next_state = ST_WAIT_GNT;
                end
            end
            ST_WAIT_GNT:
                if (p_seen)
                    next_state = ST_OWN;
            ST_OWN:
            begin
                if (s_seen)
                begin
                    next_s_low = 1'b1; // RL7 RL8
                    next_state = ST_LEND;
                end
                else if (xfer_last)
                    next_state = ST_REL;
            end
            ST_LEND:
                if (s_seen)
                begin
                    next_p_low = 1'b1; // RL21
                    next_state = ST_DEAD;
                end
            ST_REL:
            begin
                next_p_low = 1'b1; // RL21
                next_state = ST_DEAD;
            end
            ST_RELAY:
            begin
                if (gnt_cnt == `NCB_GNT_DELAY)
                begin
                    next_s_low = 1'b1; // RL20
                end
                if (gnt_cnt == `NCB_GNT_DELAY + 2'h1 && s_seen)
                begin
                    next_p_low = 1'b1; // RL20
                    next_state = ST_DEAD;
                end
            end
            ST_DEAD:
                next_state = ST_IDLE; // RL19
            default:
                next_state = ST_IDLE;
        endcase
    end

    // grant count in relay: 1 after grant seen, pulse at delay
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state <= ST_IDLE;
            p_low <= 1'b0;
            s_low <= 1'b0;
            gnt_cnt <= 2'h0;
            req_pend <= 1'b0;
            xfer_go <= 1'b0;
            bus_owned <= 1'b0;
            p_d1 <= 1'b0;
            p_d2 <= 1'b0;
            s_d1 <= 1'b0;
            s_d2 <= 1'b0;
        end
        else
        begin
            state <= next_state;
            p_low <= next_p_low;
            s_low <= next_s_low;
            // track own pulses to mask their echo on the pins
            p_d1 <= p_low;
            p_d2 <= p_d1;
            s_d1 <= s_low;
            s_d2 <= s_d1;
            // secondary master wins over a pending own request
            if (state == ST_RELAY && xfer_req)
                req_pend <= 1'b1; // RL8
            else if (next_state == ST_WAIT_GNT)
                req_pend <= 1'b0;
            if (state != ST_RELAY)
                gnt_cnt <= 2'h0;
            else if (gnt_cnt == 2'h0 && p_seen)
                gnt_cnt <= 2'h1;
            else if (gnt_cnt != 2'h0 && gnt_cnt != `NCB_GNT_DELAY + 2'h1)
                gnt_cnt <= gnt_cnt + 2'h1;
            xfer_go <= (state == ST_WAIT_GNT) && (next_state == ST_OWN); // RL6
            bus_owned <= (next_state == ST_OWN); // RL12
        end
    end
endmodule

// ---- test/ncb_host_model.sv ----
// ************
// host side of the primary handshake
// ************
module ncb_host_model #(
    parameter int GNT_WAIT = 3
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic pin,
    output logic drive_low = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int st = 0;
    int cnt = 0;
    // request seen, grant after a wait, await release, one dead cycle
    // the wait stands for a higher master still holding the bus
    always @(posedge clk_sys)
    begin
        drive_low <= 1'b0;
        if (!resetn)
            st <= 0;
        else if (st == 0 && !pin)
        begin
            st <= 1;
            cnt <= GNT_WAIT;
        end
        else if (st == 1)
        begin
            cnt <= cnt - 1;
            if (cnt == 0)
            begin
                drive_low <= 1'b1;
                st <= 2;
            end
        end
        else if (st == 2 && !drive_low && !pin)
            st <= 3;
        else if (st == 3)
            st <= 0;
    end
endmodule

// ---- test/ncb_port_chk.sv ----
// ************
// port checker
// ************
module ncb_port_chk (
    input wire clk_sys,
    input wire resetn,
    input wire primary_bus_handshake_oe,
    input wire secondary_bus_handshake_oe,
    input wire xfer_last,
    input wire xfer_go,
    input wire bus_owned,
    input wire exec_error,
    input wire esc_seen,
    input wire busy,
    input wire int_req,
    input wire [3:0] upper_status_drive,
    input wire high_byte_enable,
    input wire upper_status_seven
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    pri_pulse_a: assert property ($rose(primary_bus_handshake_oe) |=> !primary_bus_handshake_oe)
        else $error("primary pulse wider than one clock");
    sec_pulse_a: assert property ($rose(secondary_bus_handshake_oe) |=> !secondary_bus_handshake_oe)
        else $error("secondary pulse wider than one clock");
    own_status_a: assert property (bus_owned |-> upper_status_drive == 4'hb)
        else $error("upper status wrong on own cycles");
    s7_copy_a: assert property ($past(resetn) |-> upper_status_seven == $past(high_byte_enable))
        else $error("status seven differs from byte enable");
    go_owned_a: assert property (xfer_go |-> bus_owned)
        else $error("transfer start without ownership");
    rel_after_last_a: assert property (bus_owned && xfer_last |-> ##[1:2] primary_bus_handshake_oe)
        else $error("no release after last cycle");
    busy_on_esc_a: assert property (esc_seen |-> ##[0:2] busy)
        else $error("busy not raised");
    int_on_err_a: assert property (exec_error |-> ##[1:2] int_req)
        else $error("interrupt not raised");
    go_not_echo_a: assert property ($rose(primary_bus_handshake_oe) |=> (!xfer_go) [*3])
        else $error("own request taken as grant");
    sec_not_echo_a: assert property ($rose(secondary_bus_handshake_oe) |=> (!primary_bus_handshake_oe) [*3])
        else $error("own grant taken as release");
    cover property (xfer_go);
    cover property (secondary_bus_handshake_oe);
    cover property ($rose(int_req));
endmodule
bind ncb_port ncb_port_chk ncb_port_chk_i (.clk_sys(clk_sys), .resetn(resetn),
    .primary_bus_handshake_oe(primary_bus_handshake_oe), .secondary_bus_handshake_oe(secondary_bus_handshake_oe),
    .xfer_last(xfer_last), .xfer_go(xfer_go), .bus_owned(bus_owned), .exec_error(exec_error),
    .esc_seen(esc_seen), .busy(busy), .int_req(int_req), .upper_status_drive(upper_status_drive),
    .high_byte_enable(high_byte_enable), .upper_status_seven(upper_status_seven));

// ---- test/tb.sv ----
`include "ncb_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] cyc = `NCB_CYC_PASSIVE;
    logic [1:0] qst = `NCB_Q_NOP;
    logic [7:0] dat = 8'h00;
    logic st6 = 1'b1, hbe = 1'b1, xfer_req = 1'b0, xfer_last = 1'b0;
    logic exec_done = 1'b0, exec_error = 1'b0, sec_low = 1'b0;
    logic host_low, pri_out, pri_oe, sec_out, sec_oe, xfer_go, owned, esc, busy, int_req, s7;
    logic [3:0] usd;
    int err_total = 0, n_checks = 0, cyc_cnt = 0, n;
    // pull-ups when nobody drives
    wire pri_pin = pri_oe ? pri_out : !host_low;
    wire sec_pin = sec_oe ? sec_out : !sec_low;
    always #2 clk_sys = ~clk_sys;
    ncb_port ncb_port_i (.clk_sys(clk_sys), .resetn(resetn), .cycle_type_status(cyc),
        .queue_tracking_status(qst), .upper_status_six(st6), .bus_data_in(dat),
        .primary_bus_handshake_in(pri_pin), .primary_bus_handshake_out(pri_out), .primary_bus_handshake_oe(pri_oe),
        .secondary_bus_handshake_in(sec_pin), .secondary_bus_handshake_out(sec_out),
        .secondary_bus_handshake_oe(sec_oe), .xfer_req(xfer_req), .xfer_last(xfer_last), .xfer_go(xfer_go),
        .bus_owned(owned), .exec_done(exec_done), .exec_error(exec_error), .esc_seen(esc), .busy(busy),
        .int_req(int_req), .upper_status_drive(usd), .high_byte_enable(hbe), .upper_status_seven(s7));
    ncb_host_model ncb_host_model_i (.clk_sys(clk_sys), .resetn(resetn), .pin(pri_pin), .drive_low(host_low));
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    // waits for an output, pulse inputs dropped after one edge
    task automatic wt(input int w, output int k);
        logic s;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            if (k == 0)
                {xfer_last, sec_low, exec_error, exec_done} = 4'h0;
            s = w == 0 ? pri_oe : w == 1 ? sec_oe : w == 2 ? xfer_go : esc;
            k++;
        end
        while (s !== 1'b1 && k < 20);
    endtask
    // lets c edges pass, inputs change just after the last
    task automatic gap(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_own();
        xfer_req = 1'b1;
        wt(0, n);
        chk(n < 20, "no bus request");
        wt(2, n);
        xfer_req = 1'b0;
        chk(n < 20 && owned === 1'b1, "no ownership");
        chk(usd === 4'hb, "upper status");
        hbe = 1'b0;
        wt(3, n);
        chk(s7 === 1'b0, "status seven");
        hbe = 1'b1;
        sec_low = 1'b1;
        wt(1, n);
        chk(n < 20, "no direct grant");
        repeat (2) wt(3, n);
        sec_low = 1'b1;
        wt(0, n);
        chk(n <= 4 && owned === 1'b0, "no release after lend");
        gap(4);
        xfer_req = 1'b1;
        wt(2, n);
        xfer_req = 1'b0;
        chk(n < 20 && owned === 1'b1, "no second ownership");
        xfer_last = 1'b1;
        wt(0, n);
        chk(n <= 2, "late release");
    endtask
    task automatic t_relay();
        sec_low = 1'b1;
        wt(0, n);
        chk(n <= 4 && owned === 1'b0, "request relay");
        wt(1, n);
        chk(n < 20, "grant relay");
        repeat (2) wt(3, n);
        sec_low = 1'b1;
        wt(0, n);
        chk(n <= 4, "release relay");
    endtask
    task automatic t_exec();
        {cyc, st6, dat} = {`NCB_CYC_FETCH, 1'b0, 8'hda};
        gap(3);
        qst = `NCB_Q_FIRST;
        wt(3, n);
        chk(n < 20, "escape missed");
        {cyc, qst, st6} = {`NCB_CYC_PASSIVE, `NCB_Q_NOP, 1'b1};
        gap(4);
        chk(busy === 1'b1, "busy");
        exec_error = 1'b1;
        wt(3, n);
        chk(int_req === 1'b1, "interrupt");
        exec_done = 1'b1;
        wt(3, n);
        chk(busy === 1'b1, "busy dropped under exception");
        {cyc, st6} = {`NCB_CYC_FETCH, 1'b0};
        gap(3);
        qst = `NCB_Q_FIRST;
        wt(3, n);
        {cyc, qst, st6} = {`NCB_CYC_PASSIVE, `NCB_Q_NOP, 1'b1};
        gap(4);
        chk(int_req === 1'b0 && busy === 1'b1, "exception not cleared");
        exec_done = 1'b1;
        wt(3, n);
        chk(busy === 1'b0, "busy stuck");
        {cyc, st6, dat} = {`NCB_CYC_FETCH, 1'b1, 8'hdc};
        gap(3);
        qst = `NCB_Q_FIRST;
        wt(3, n);
        chk(n == 20, "foreign escape taken");
        {cyc, qst} = {`NCB_CYC_PASSIVE, `NCB_Q_NOP};
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk_sys)
    begin
        cyc_cnt++;
        if (cyc_cnt == 3000)
        begin
            err_total++;
            stop_test();
        end
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (3) wt(3, n);
        chk(pri_oe === 1'b0 && sec_oe === 1'b0 && busy === 1'b0, "reset state");
        t_own();
        repeat (6) wt(3, n);
        t_relay();
        repeat (6) wt(3, n);
        t_exec();
        stop_test();
    end
endmodule
